// *** inc/ueb_dma_if.sv ***
// Interface between the token logic and the DMA address generator.
interface ueb_dma_if;
	logic start;
	logic step;
	logic [31:0] base;
	logic [9:0] ofs;
	logic [9:0] maxlen;
	logic [31:0] addr;
	logic room;

	// The token logic loads and steps; the generator answers.
	modport ctl (output start, output step, output base, output ofs,
		output maxlen, input addr, input room);
	modport gen (input start, input step, input base, input ofs,
		input maxlen, output addr, output room);
endinterface

// *** inc/ueb_pkg.sv ***
// Constants, register map and endpoint layout of the USB endpoint buffer block.
//
// Summary of operation
// - Endpoint zero always enabled; others enabled separately.
// - Stalls persist until software clears them.
// - IN and OUT share one maximum packet.
// - Endpoint zero: 8 bytes, offsets 0x000/0x008.
// - Endpoint one: 8 bytes, offsets 0x010/0x018.
// - Endpoint two: 8 bytes, offsets 0x020/0x028.
// - Endpoint three: 64 bytes, offsets 0x030/0x070.
// - Endpoint four: 32 bytes, offsets 0x0b0/0x0d0.
// - Endpoint five: 64 bytes, offsets 0x0f0/0x130.
// - Endpoint six isochronous: 512 bytes, 0x170/0x370.
// - All endpoint buffers packed in one RAM block.
// - Region A always; region B only double-buffered.
// - Separate base settings for regions A and B.
// - Silent on bus until configured and enabled.
// - Bulk and interrupt endpoints handled identically.
// - USB and second serial controller share pins exclusively.
// - Full speed only; requests derived 48 MHz clock.
// - Double buffering enabled per physical direction.
package ueb_pkg;

	// Register byte addresses.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_IN_EN = 8'h04;
	localparam logic [7:0] OFS_OUT_EN = 8'h08;
	localparam logic [7:0] OFS_IN_STALL = 8'h0c;
	localparam logic [7:0] OFS_OUT_STALL = 8'h10;
	localparam logic [7:0] OFS_BASE_A = 8'h14;
	localparam logic [7:0] OFS_BASE_B = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;

	// Control register field positions.
	localparam int CTRL_DEV_EN = 0;
	localparam int CTRL_USB_PINS = 1;
	localparam int CTRL_DBUF_IN = 8;
	localparam int CTRL_DBUF_OUT = 16;

	// Status register field positions.
	localparam int STAT_BUSY = 0;
	localparam int STAT_DIR_IN = 1;
	localparam int STAT_OVERRUN = 2;
	localparam int STAT_EP = 4;
	localparam int STAT_SEL_IN = 8;
	localparam int STAT_SEL_OUT = 16;

	// Reset values.
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [6:0] EN_RST = 7'h01;
	localparam logic [6:0] STALL_RST = 7'h00;
	localparam logic [28:0] BASE_RST = 29'h0000_0000;

	// Endpoint layout.
	localparam int NUM_EP = 7;
	localparam logic [9:0] EP_IN_OFS [0:6] = '{10'h000, 10'h010, 10'h020,
		10'h030, 10'h0b0, 10'h0f0, 10'h170};
	localparam logic [9:0] EP_OUT_OFS [0:6] = '{10'h008, 10'h018, 10'h028,
		10'h070, 10'h0d0, 10'h130, 10'h370};
	localparam logic [9:0] EP_MAXPKT [0:6] = '{10'h008, 10'h008, 10'h008,
		10'h040, 10'h020, 10'h040, 10'h200};

	// Token handling states.
	typedef enum logic [1:0] {
		ueb_idle,
		ueb_xfer
	} ueb_state_t;

endpackage

// *** logic/ueb_core.sv ***
// Endpoint control, buffer selection and DMA sequencing with AHB-Lite regs.
module ueb_core (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Token side from the serial interface engine.
	input wire logic tok_valid,
	input wire logic [2:0] tok_ep,
	input wire logic tok_in,
	input wire logic byte_stb,
	input wire logic [7:0] rx_data,
	input wire logic pkt_end,
	// Handshake answer to the engine.
	output logic hs_valid,
	output logic hs_stall,
	output logic xfer_active,
	// DMA port to the buffer RAM.
	output logic [31:0] dma_addr,
	output logic dma_wr,
	output logic dma_rd,
	output logic [7:0] dma_wdata,
	input wire logic [7:0] dma_rdata,
	output logic tx_valid,
	output logic [7:0] tx_data,
	// Pin ownership and clock request.
	output logic usb_pins_own,
	output logic serial_pins_own,
	output logic usb_clk_req
);

	ueb_dma_if dif ();

	// Register state.
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [6:0] in_en_r, in_en_nxt;
	logic [6:0] out_en_r, out_en_nxt;
	logic [6:0] in_stall_r, in_stall_nxt;
	logic [6:0] out_stall_r, out_stall_nxt;
	logic [28:0] base_a_r, base_a_nxt;
	logic [28:0] base_b_r, base_b_nxt;
	logic overrun_r, overrun_nxt;

	// Bus state.
	logic wr_pend_r, wr_pend_nxt;
	logic rd_pend_r, rd_pend_nxt;
	logic [7:0] bus_addr_r, bus_addr_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic hready_r, hready_nxt;

	// Transfer state.
	ueb_pkg::ueb_state_t state_r, state_nxt;
	logic [2:0] cur_ep_r, cur_ep_nxt;
	logic cur_in_r, cur_in_nxt;
	logic [6:0] sel_in_r, sel_in_nxt;
	logic [6:0] sel_out_r, sel_out_nxt;
	logic hs_valid_r, hs_valid_nxt;
	logic hs_stall_r, hs_stall_nxt;
	logic [31:0] dma_addr_r, dma_addr_nxt;
	logic dma_wr_r, dma_wr_nxt;
	logic dma_rd_r, dma_rd_nxt;
	logic [7:0] dma_wdata_r, dma_wdata_nxt;
	logic tx_valid_r, tx_valid_nxt;
	logic own_usb_r, own_serial_r, clk_req_r;

	// Lookup results and derived controls.
	logic tok_exists;
	logic [9:0] tok_ofs, tok_max;
	logic [9:0] unused_ofs, unused_max;
	logic unused_exists;
	logic dev_live;
	logic ahb_go;
	logic [6:0] dbuf_in, dbuf_out;
	logic use_b;

	// Decode the register that a byte address names; unmapped reads zero.
	function automatic logic [31:0] reg_read(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			ueb_pkg::OFS_CTRL: v = ctrl_r;
			ueb_pkg::OFS_IN_EN: v = {25'h000_0000, in_en_r};
			ueb_pkg::OFS_OUT_EN: v = {25'h000_0000, out_en_r};
			ueb_pkg::OFS_IN_STALL: v = {25'h000_0000, in_stall_r};
			ueb_pkg::OFS_OUT_STALL: v = {25'h000_0000, out_stall_r};
			ueb_pkg::OFS_BASE_A: v = {base_a_r, 3'h0};
			ueb_pkg::OFS_BASE_B: v = {base_b_r, 3'h0};
			ueb_pkg::OFS_STATUS: begin
				v[ueb_pkg::STAT_BUSY] = (state_r == ueb_pkg::ueb_xfer);
				v[ueb_pkg::STAT_DIR_IN] = cur_in_r;
				v[ueb_pkg::STAT_OVERRUN] = overrun_r;
				v[ueb_pkg::STAT_EP +: 3] = cur_ep_r;
				v[ueb_pkg::STAT_SEL_IN +: 7] = sel_in_r;
				v[ueb_pkg::STAT_SEL_OUT +: 7] = sel_out_r;
			end
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// Token lookup for the endpoint addressed right now.
	ueb_ep_table u_tok_table (
		.ep(tok_ep),
		.dir_in(tok_in),
		.exists(tok_exists),
		.ofs(tok_ofs),
		.maxlen(tok_max)
	);

	// Lookup for the transfer in flight; feeds the address generator.
	ueb_ep_table u_cur_table (
		.ep(cur_ep_r),
		.dir_in(cur_in_r),
		.exists(unused_exists),
		.ofs(unused_ofs),
		.maxlen(unused_max)
	);

	// Address generator.
	ueb_dma_agen u_agen (
		.hclk(hclk),
		.hresetn(hresetn),
		.dif(dif.gen)
	);

	// The block listens only once enabled and owning the data pins.
	assign dev_live = ctrl_r[ueb_pkg::CTRL_DEV_EN]
		&& ctrl_r[ueb_pkg::CTRL_USB_PINS];
	assign ahb_go = hsel && htrans[1] && hready;
	assign dbuf_in = ctrl_r[ueb_pkg::CTRL_DBUF_IN +: 7];
	assign dbuf_out = ctrl_r[ueb_pkg::CTRL_DBUF_OUT +: 7];

	// Region B serves a direction only with its double buffering on.
	always_comb begin
		if (cur_in_r) begin
			use_b = dbuf_in[cur_ep_r] && sel_in_r[cur_ep_r];
		end else begin
			use_b = dbuf_out[cur_ep_r] && sel_out_r[cur_ep_r];
		end
	end

	// Generator inputs: the region base comes from the chosen setting.
	assign dif.base = use_b ? {base_b_r, 3'h0}
		: {base_a_r, 3'h0};
	assign dif.ofs = unused_ofs;
	assign dif.maxlen = unused_max;
	assign dif.start = (state_r == ueb_pkg::ueb_idle);
	assign dif.step = (state_r == ueb_pkg::ueb_xfer) && byte_stb;

	// AHB sequencing: writes have no wait, reads take one wait state so
	// that a write in the preceding data phase is visible to the read.
	always_comb begin
		wr_pend_nxt = 1'b0;
		rd_pend_nxt = 1'b0;
		bus_addr_nxt = bus_addr_r;
		hrdata_nxt = hrdata_r;
		hready_nxt = 1'b1;
		if (rd_pend_r) begin
			// Second cycle of a read: data and ready together.
			hrdata_nxt = reg_read(bus_addr_r);
		end else if (ahb_go) begin
			bus_addr_nxt = {haddr[7:2], 2'h0};
			wr_pend_nxt = hwrite;
			rd_pend_nxt = !hwrite;
			hready_nxt = hwrite;
		end
	end

	// Bus state registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			bus_addr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
			hready_r <= 1'b1;
		end else begin
			wr_pend_r <= wr_pend_nxt;
			rd_pend_r <= rd_pend_nxt;
			bus_addr_r <= bus_addr_nxt;
			hrdata_r <= hrdata_nxt;
			hready_r <= hready_nxt;
		end
	end

	// Register writes; hardware touches only the overrun flag.
	always_comb begin
		ctrl_nxt = ctrl_r;
		in_en_nxt = in_en_r;
		out_en_nxt = out_en_r;
		in_stall_nxt = in_stall_r;
		out_stall_nxt = out_stall_r;
		base_a_nxt = base_a_r;
		base_b_nxt = base_b_r;
		overrun_nxt = overrun_r;
		if (wr_pend_r) begin
			unique case (bus_addr_r)
				ueb_pkg::OFS_CTRL: ctrl_nxt = hwdata;
				// Endpoint zero cannot be switched off.
				ueb_pkg::OFS_IN_EN: in_en_nxt = hwdata[6:0] | 7'h01;
				ueb_pkg::OFS_OUT_EN: out_en_nxt = hwdata[6:0] | 7'h01;
				// Only these writes ever change a stall bit.
				ueb_pkg::OFS_IN_STALL: in_stall_nxt = hwdata[6:0];
				ueb_pkg::OFS_OUT_STALL: out_stall_nxt = hwdata[6:0];
				// Low three address bits are not stored; software aligns.
				ueb_pkg::OFS_BASE_A: base_a_nxt = hwdata[31:3];
				ueb_pkg::OFS_BASE_B: base_b_nxt = hwdata[31:3];
				ueb_pkg::OFS_STATUS: begin
					if (hwdata[ueb_pkg::STAT_OVERRUN]) begin
						overrun_nxt = 1'b0;
					end
				end
				default: ctrl_nxt = ctrl_r;
			endcase
		end
		// A dropped byte sets the flag even in the cycle of a clear.
		if (dif.step && !dif.room) begin
			overrun_nxt = 1'b1;
		end
	end

	// Register file.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= ueb_pkg::CTRL_RST;
			in_en_r <= ueb_pkg::EN_RST;
			out_en_r <= ueb_pkg::EN_RST;
			in_stall_r <= ueb_pkg::STALL_RST;
			out_stall_r <= ueb_pkg::STALL_RST;
			base_a_r <= ueb_pkg::BASE_RST;
			base_b_r <= ueb_pkg::BASE_RST;
			overrun_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			in_en_r <= in_en_nxt;
			out_en_r <= out_en_nxt;
			in_stall_r <= in_stall_nxt;
			out_stall_r <= out_stall_nxt;
			base_a_r <= base_a_nxt;
			base_b_r <= base_b_nxt;
			overrun_r <= overrun_nxt;
		end
	end

	// Token handling and byte movement. Endpoint kind plays no part:
	// bulk and interrupt endpoints run the same path.
	always_comb begin
		state_nxt = state_r;
		cur_ep_nxt = cur_ep_r;
		cur_in_nxt = cur_in_r;
		sel_in_nxt = sel_in_r;
		sel_out_nxt = sel_out_r;
		hs_valid_nxt = 1'b0;
		hs_stall_nxt = 1'b0;
		dma_addr_nxt = dma_addr_r;
		dma_wr_nxt = 1'b0;
		dma_rd_nxt = 1'b0;
		dma_wdata_nxt = dma_wdata_r;
		// Read data arrives from the RAM one cycle after the strobe.
		tx_valid_nxt = dma_rd_r;
		unique case (state_r)
			ueb_pkg::ueb_idle: begin
				if (tok_valid && dev_live && tok_exists) begin
					if (tok_in ? in_stall_r[tok_ep] : out_stall_r[tok_ep]) begin
						// Stalled direction answers with STALL.
						hs_valid_nxt = 1'b1;
						hs_stall_nxt = 1'b1;
					end else if (tok_in ? in_en_r[tok_ep]
						: out_en_r[tok_ep]) begin
						// Enabled direction accepts and opens a transfer.
						hs_valid_nxt = 1'b1;
						cur_ep_nxt = tok_ep;
						cur_in_nxt = tok_in;
						state_nxt = ueb_pkg::ueb_xfer;
					end
					// A disabled direction gets no answer at all.
				end
			end
			ueb_pkg::ueb_xfer: begin
				if (byte_stb && dif.room) begin
					// IN data is read from RAM, OUT data written to it.
					dma_addr_nxt = dif.addr;
					dma_wr_nxt = !cur_in_r;
					dma_rd_nxt = cur_in_r;
					dma_wdata_nxt = rx_data;
				end
				if (pkt_end) begin
					// A finished packet swaps regions where double buffered.
					if (cur_in_r && dbuf_in[cur_ep_r]) begin
						sel_in_nxt[cur_ep_r] = !sel_in_r[cur_ep_r];
					end
					if (!cur_in_r && dbuf_out[cur_ep_r]) begin
						sel_out_nxt[cur_ep_r] = !sel_out_r[cur_ep_r];
					end
					state_nxt = ueb_pkg::ueb_idle;
				end
			end
		endcase
	end

	// Transfer registers and pin ownership.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= ueb_pkg::ueb_idle;
			cur_ep_r <= 3'h0;
			cur_in_r <= 1'b0;
			sel_in_r <= 7'h00;
			sel_out_r <= 7'h00;
			hs_valid_r <= 1'b0;
			hs_stall_r <= 1'b0;
			dma_addr_r <= 32'h0000_0000;
			dma_wr_r <= 1'b0;
			dma_rd_r <= 1'b0;
			dma_wdata_r <= 8'h00;
			tx_valid_r <= 1'b0;
			tx_data <= 8'h00;
			own_usb_r <= 1'b0;
			own_serial_r <= 1'b1;
			clk_req_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cur_ep_r <= cur_ep_nxt;
			cur_in_r <= cur_in_nxt;
			sel_in_r <= sel_in_nxt;
			sel_out_r <= sel_out_nxt;
			hs_valid_r <= hs_valid_nxt;
			hs_stall_r <= hs_stall_nxt;
			dma_addr_r <= dma_addr_nxt;
			dma_wr_r <= dma_wr_nxt;
			dma_rd_r <= dma_rd_nxt;
			dma_wdata_r <= dma_wdata_nxt;
			tx_valid_r <= tx_valid_nxt;
			if (dma_rd_r) begin
				tx_data <= dma_rdata;
			end
			// Exactly one owner of the two shared data pins.
			own_usb_r <= ctrl_r[ueb_pkg::CTRL_USB_PINS];
			own_serial_r <= !ctrl_r[ueb_pkg::CTRL_USB_PINS];
			// Enabled device asks the clock unit for its 48 MHz clock.
			clk_req_r <= ctrl_r[ueb_pkg::CTRL_DEV_EN];
		end
	end

	// Outputs straight from flip-flops, xfer_active decoded from state_r; the response is always OKAY.
	assign hrdata = hrdata_r;
	assign hreadyout = hready_r;
	assign hresp = 1'b0;
	assign hs_valid = hs_valid_r;
	assign hs_stall = hs_stall_r;
	assign xfer_active = (state_r == ueb_pkg::ueb_xfer);
	assign dma_addr = dma_addr_r;
	assign dma_wr = dma_wr_r;
	assign dma_rd = dma_rd_r;
	assign dma_wdata = dma_wdata_r;
	assign tx_valid = tx_valid_r;
	assign usb_pins_own = own_usb_r;
	assign serial_pins_own = own_serial_r;
	assign usb_clk_req = clk_req_r;

endmodule // ueb_core

// *** logic/ueb_dma_agen.sv ***
// DMA address generator for one packet transfer.
module ueb_dma_agen (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Control from the token logic.
	ueb_dma_if.gen dif
);

	logic [9:0] idx_r; // Byte index within the packet.
	logic [9:0] idx_nxt; // Next byte index.

	// Restart on a new packet, advance per moved byte while room remains.
	always_comb begin
		idx_nxt = idx_r;
		if (dif.start) begin
			idx_nxt = 10'h000;
		end else if (dif.step && dif.room) begin
			idx_nxt = idx_r + 10'h001;
		end
	end

	// Index register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx_r <= 10'h000;
		end else begin
			idx_r <= idx_nxt;
		end
	end

	// Base plus fixed offset plus byte index.
	assign dif.addr = dif.base + {22'h00_0000, dif.ofs}
		+ {22'h00_0000, idx_r};
	// Bytes past the maximum packet get no address.
	assign dif.room = (idx_r < dif.maxlen);

endmodule // ueb_dma_agen

// *** logic/ueb_ep_table.sv ***
// Endpoint lookup: buffer offset and maximum packet per direction.
module ueb_ep_table (
	// Query.
	input wire logic [2:0] ep,
	input wire logic dir_in,
	// Answer.
	output logic exists,
	output logic [9:0] ofs,
	output logic [9:0] maxlen
);

	// Pure table lookup; endpoint seven does not exist.
	always_comb begin
		exists = (ep < 3'(ueb_pkg::NUM_EP));
		ofs = 10'h000;
		maxlen = 10'h000;
		if (exists) begin
			// Offsets pack every direction into one RAM block.
			if (dir_in) begin
				ofs = ueb_pkg::EP_IN_OFS[ep];
			end else begin
				ofs = ueb_pkg::EP_OUT_OFS[ep];
			end
			// One packet size serves both directions.
			maxlen = ueb_pkg::EP_MAXPKT[ep];
		end
	end

endmodule // ueb_ep_table

// *** verif/ueb_core_props.sv ***
// Port checker of the USB endpoint buffer block, bound to its top.
module ueb_core_props (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Link side.
	input wire logic tok_valid,
	input wire logic [2:0] tok_ep,
	input wire logic byte_stb,
	input wire logic pkt_end,
	input wire logic hs_valid,
	input wire logic hs_stall,
	input wire logic xfer_active,
	// Buffer RAM and pins.
	input wire logic dma_wr,
	input wire logic dma_rd,
	input wire logic tx_valid,
	input wire logic usb_pins_own,
	input wire logic serial_pins_own
);
	timeunit 1ns;
	timeprecision 1ps;
	// All checks share the bus clock and its reset.
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// A handshake is only ever the answer to the token just before it.
	AST_HS_CAUSE: assert property (hs_valid |-> $past(tok_valid))
		else $error("Handshake without a preceding token.");
	// Without pin ownership a token gets no answer at all.
	AST_SILENT: assert property (
		tok_valid ##1 !usb_pins_own |-> !hs_valid)
		else $error("Answer while the pins are not owned.");
	// There is no endpoint seven.
	AST_NO_EP7: assert property (
		tok_valid && tok_ep == 3'h7 |=> !hs_valid)
		else $error("Answer to a token for endpoint seven.");
	// A stall answer never opens a transfer.
	AST_STALL: assert property (
		hs_stall |-> hs_valid && !xfer_active ##1 !xfer_active)
		else $error("Stall answer opened a transfer.");
	// A transfer opens only with an accepting handshake.
	AST_OPEN: assert property (
		$rose(xfer_active) |-> hs_valid && !hs_stall)
		else $error("Transfer opened without an accepting handshake.");
	// The end of a packet closes the transfer in the next cycle.
	AST_CLOSE: assert property (
		pkt_end && xfer_active |=> !xfer_active)
		else $error("Transfer still open after packet end.");
	// Every RAM write carries a byte received inside a transfer.
	AST_WR: assert property (
		dma_wr |-> $past(byte_stb) && $past(xfer_active))
		else $error("RAM write without a received byte.");
	// A RAM read follows a byte request and yields a byte next cycle.
	AST_RD: assert property (
		dma_rd |-> $past(byte_stb) ##1 tx_valid)
		else $error("RAM read not tied to a byte request.");
	// The shared pins always belong to exactly one owner.
	AST_PINS: assert property (usb_pins_own != serial_pins_own)
		else $error("Data pins owned by both or neither.");

	// Main scenarios reached.
	cover property (hs_valid && hs_stall);
	cover property (dma_wr);
	cover property (tx_valid);
endmodule // ueb_core_props

bind ueb_core ueb_core_props ueb_core_props_inst (.hclk, .hresetn,
	.tok_valid, .tok_ep, .byte_stb, .pkt_end, .hs_valid, .hs_stall,
	.xfer_active, .dma_wr, .dma_rd, .tx_valid, .usb_pins_own,
	.serial_pins_own);

// *** verif/ueb_core_tb.sv ***
// Self-checking bench of the USB endpoint buffer block.
module ueb_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Clock, reset and bus master.
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic hreadyout, hresp;
	// Link side, driven by the host model.
	logic tok_valid, tok_in, byte_stb, pkt_end, hs_valid, hs_stall;
	logic [2:0] tok_ep;
	logic [7:0] rx_data, dma_wdata, tx_data;
	logic xfer_active, dma_wr, dma_rd, tx_valid;
	logic usb_pins_own, serial_pins_own, usb_clk_req;
	logic [31:0] dma_addr;
	// Buffer RAM beside the block; reads answer at once.
	logic [7:0] mem [0:4095];
	wire [7:0] dma_rdata = mem[dma_addr[11:0]];
	// Counters, scratch and expected layout.
	int err_total = 0;
	int num_checks = 0;
	logic [31:0] rd;
	logic got, st;
	localparam logic [11:0] BA = 12'h100;
	localparam logic [11:0] BB = 12'h800;
	localparam logic [11:0] IN_OFS [0:6] = '{12'h000, 12'h010, 12'h020,
		12'h030, 12'h0b0, 12'h0f0, 12'h170};
	localparam logic [11:0] OUT_OFS [0:6] = '{12'h008, 12'h018, 12'h028,
		12'h070, 12'h0d0, 12'h130, 12'h370};

	// Free-running 100 MHz clock.
	always #5 hclk = ~hclk;

	ueb_core ueb_core_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .tok_valid, .tok_ep, .tok_in, .byte_stb,
		.rx_data, .pkt_end, .hs_valid, .hs_stall, .xfer_active, .dma_addr,
		.dma_wr, .dma_rd, .dma_wdata, .dma_rdata, .tx_valid, .tx_data,
		.usb_pins_own, .serial_pins_own, .usb_clk_req);
	ueb_host_model ueb_host_model_inst (.hclk, .tok_valid, .tok_ep,
		.tok_in, .byte_stb, .rx_data, .pkt_end, .hs_valid, .hs_stall,
		.tx_valid, .tx_data);

	// The block stores OUT bytes into the RAM.
	always @(posedge hclk) begin
		if (dma_wr === 1'b1) begin
			mem[dma_addr[11:0]] <= dma_wdata;
		end
	end

	// Comparisons for words, bytes and flags.
	task automatic chk_word(string n, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_byte(string n, logic [7:0] e, logic [7:0] g);
		chk_word(n, {24'h00_0000, e}, {24'h00_0000, g});
	endtask
	task automatic chk_bit(string n, logic e, logic g);
		chk_word(n, {31'h0000_0000, e}, {31'h0000_0000, g});
	endtask

	// One AHB-Lite word transfer; a read leaves its data in rd.
	task automatic ahb(logic wr, logic [7:0] a, logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		// Only the watchdog ends a wait for the data phase.
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdchk(logic [7:0] a, logic [31:0] e);
		ahb(1'b0, a, 32'h0000_0000);
		chk_word($sformatf("reg_%h", a), e, rd);
	endtask

	// Reset values, and silence before the block is switched on.
	task automatic t_regs();
		rdchk(ueb_pkg::OFS_CTRL, 32'h0000_0000);
		rdchk(ueb_pkg::OFS_IN_EN, 32'h0000_0001);
		rdchk(ueb_pkg::OFS_OUT_EN, 32'h0000_0001);
		rdchk(ueb_pkg::OFS_IN_STALL, 32'h0000_0000);
		rdchk(ueb_pkg::OFS_BASE_B, 32'h0000_0000);
		rdchk(8'h40, 32'h0000_0000);
		chk_bit("serial_pins_own", 1'b1, serial_pins_own);
		chk_bit("usb_clk_req", 1'b0, usb_clk_req);
		ueb_host_model_inst.token(3'h0, 1'b0, got, st);
		chk_bit("early_answer", 1'b0, got);
	endtask

	// Aligned bases first, then enables, then the device itself.
	task automatic t_setup();
		ahb(1'b1, ueb_pkg::OFS_BASE_A, {20'h0_0000, BA});
		ahb(1'b1, ueb_pkg::OFS_BASE_B, {20'h0_0000, BB});
		ahb(1'b1, ueb_pkg::OFS_IN_EN, 32'h0000_007e);
		rdchk(ueb_pkg::OFS_IN_EN, 32'h0000_007f);
		ahb(1'b1, ueb_pkg::OFS_OUT_EN, 32'h0000_007f);
		ahb(1'b1, ueb_pkg::OFS_CTRL, 32'h0000_0003);
		rdchk(ueb_pkg::OFS_BASE_B, {20'h0_0000, BB});
		chk_bit("usb_pins_own", 1'b1, usb_pins_own);
		chk_bit("usb_clk_req", 1'b1, usb_clk_req);
	endtask

	// Each direction of each endpoint uses its own slot of region A.
	task automatic t_layout();
		logic [7:0] d;
		for (int ep = 0; ep < 7; ep++) begin
			d = 8'(8'h30 + ep);
			ueb_host_model_inst.token(3'(ep), 1'b0, got, st);
			chk_bit("out_accept", 1'b1, got & ~st);
			ueb_host_model_inst.send(2, 0, d);
			chk_byte("out_b0", d, mem[BA + OUT_OFS[ep]]);
			chk_byte("out_b1", d + 8'h01, mem[BA + OUT_OFS[ep] + 12'h001]);
			mem[BA + IN_OFS[ep]] = ~d;
			ueb_host_model_inst.inq.delete();
			ueb_host_model_inst.token(3'(ep), 1'b1, got, st);
			ueb_host_model_inst.send(1, 1, 8'h00);
			chk_byte("in_b0", ~d, ueb_host_model_inst.inq[0]);
			chk_bit("in_accept", 1'b1, got & ~st);
		end
	endtask

	// Nine bytes into the eight-byte control slot: the ninth is dropped.
	task automatic t_overrun();
		mem[BA + 12'h010] = 8'h5a;
		ueb_host_model_inst.token(3'h0, 1'b0, got, st);
		ueb_host_model_inst.send(9, 0, 8'h70);
		chk_byte("last_byte", 8'h77, mem[BA + 12'h00f]);
		chk_byte("past_end", 8'h5a, mem[BA + 12'h010]);
		rdchk(ueb_pkg::OFS_STATUS, 32'h0000_0004);
		ahb(1'b1, ueb_pkg::OFS_STATUS, 32'h0000_0004);
		rdchk(ueb_pkg::OFS_STATUS, 32'h0000_0000);
	endtask

	// Disabled directions stay silent; endpoint zero never turns off.
	task automatic t_disable();
		ahb(1'b1, ueb_pkg::OFS_IN_EN, 32'h0000_0000);
		ueb_host_model_inst.token(3'h2, 1'b1, got, st);
		chk_bit("off_answer", 1'b0, got);
		ueb_host_model_inst.token(3'h0, 1'b1, got, st);
		chk_bit("ep0_answer", 1'b1, got);
		ueb_host_model_inst.send(0, 0, 8'h00);
		ueb_host_model_inst.token(3'h7, 1'b0, got, st);
		chk_bit("ep7_answer", 1'b0, got);
		ahb(1'b1, ueb_pkg::OFS_IN_EN, 32'h0000_007f);
	endtask

	// A stall outlives other traffic and only a write clears it.
	task automatic t_stall();
		ahb(1'b1, ueb_pkg::OFS_IN_STALL, 32'h0000_0004);
		ueb_host_model_inst.token(3'h2, 1'b1, got, st);
		chk_bit("stall", 1'b1, got & st);
		ueb_host_model_inst.token(3'h2, 1'b0, got, st);
		chk_bit("out_free", 1'b1, got & ~st);
		ueb_host_model_inst.send(1, 0, 8'h11);
		ahb(1'b1, ueb_pkg::OFS_IN_EN, 32'h0000_007f);
		ueb_host_model_inst.token(3'h2, 1'b1, got, st);
		chk_bit("stall_kept", 1'b1, got & st);
		ahb(1'b1, ueb_pkg::OFS_IN_STALL, 32'h0000_0000);
		ueb_host_model_inst.token(3'h2, 1'b1, got, st);
		chk_bit("unstalled", 1'b1, got & ~st);
		ueb_host_model_inst.send(0, 0, 8'h00);
	endtask

	// Endpoint one OUT alternates regions; endpoint two stays in A.
	task automatic t_dbuf();
		ahb(1'b1, ueb_pkg::OFS_CTRL, 32'h0002_0003);
		for (int k = 0; k < 2; k++) begin
			ueb_host_model_inst.token(3'h1, 1'b0, got, st);
			ueb_host_model_inst.send(1, 2, 8'(8'h90 + k));
			ueb_host_model_inst.token(3'h2, 1'b0, got, st);
			ueb_host_model_inst.send(1, 2, 8'(8'ha0 + k));
		end
		chk_byte("region_a", 8'h90, mem[BA + 12'h018]);
		chk_byte("region_b", 8'h91, mem[BB + 12'h018]);
		chk_byte("single", 8'ha1, mem[BA + 12'h028]);
	endtask

	// Counts, verdict and end of the run.
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Main sequence.
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 8'h00;
		end
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_setup();
		t_layout();
		t_overrun();
		t_disable();
		t_stall();
		t_dbuf();
		stop_test();
	end

	// Watchdog: the sequence needs a few thousand cycles at most.
	initial begin
		repeat (20000) @(posedge hclk);
		err_total++;
		stop_test();
	end
endmodule // ueb_core_tb

// *** verif/ueb_host_model.sv ***
// Behavioural full-speed host: tokens and packet bytes toward the block.
module ueb_host_model (
	// Clock.
	input wire logic hclk,
	// Token and data toward the block.
	output logic tok_valid,
	output logic [2:0] tok_ep,
	output logic tok_in,
	output logic byte_stb,
	output logic [7:0] rx_data,
	output logic pkt_end,
	// Answers from the block.
	input wire logic hs_valid,
	input wire logic hs_stall,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// Bytes sent by the block, oldest first.
	logic [7:0] inq [$];

	// The link is quiet until the bench starts traffic.
	initial begin
		tok_valid = 1'b0;
		tok_ep = 3'h0;
		tok_in = 1'b0;
		byte_stb = 1'b0;
		rx_data = 8'h00;
		pkt_end = 1'b0;
	end

	// Collect each byte in the one cycle it stands.
	always @(posedge hclk) begin
		if (tx_valid === 1'b1) begin
			inq.push_back(tx_data);
		end
	end

	// One token; the handshake is read in the cycle that follows.
	task automatic token(input logic [2:0] ep, input logic dir_in,
		output logic got, output logic st);
		@(posedge hclk);
		tok_valid <= 1'b1;
		tok_ep <= ep;
		tok_in <= dir_in;
		@(posedge hclk);
		tok_valid <= 1'b0;
		// Released lines show garbage, so stale values cannot help.
		tok_ep <= ~ep;
		tok_in <= ~dir_in;
		#1;
		got = hs_valid;
		st = hs_stall;
	endtask

	// Byte strobes with an optional gap, then the end of the packet.
	task automatic send(input int n, input int gap, input logic [7:0] d0);
		for (int i = 0; i < n; i++) begin
			@(posedge hclk);
			byte_stb <= 1'b1;
			rx_data <= d0 + 8'(i);
			@(posedge hclk);
			byte_stb <= 1'b0;
			rx_data <= ~(d0 + 8'(i));
			repeat (gap) @(posedge hclk);
		end
		@(posedge hclk);
		pkt_end <= 1'b1;
		@(posedge hclk);
		pkt_end <= 1'b0;
	endtask
endmodule // ueb_host_model
